// ===== rtl/map_ctrl_word.sv
`timescale 1ns/1ps
// =========================================================
// memory_access_port control word with APB register slave
module map_ctrl_word
    import map_pkg::*;
#(
    parameter map_variant_t VARIANT    = MAP_AHB5,
    parameter bit           HAS_ENABLE = 1'b1, // access enable pin present
    parameter bit           HAS_SECURE = 1'b1  // secure debug supported
)(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // pins
    input  wire logic        accessEnableIn,
    input  wire logic        securePermitIn,
    input  wire logic        abortIn,
    // memory side
    output logic             memReq,
    output logic [31:0]      memAddr,
    output logic             memWrite,
    output logic [2:0]       memSize,
    output logic [63:0]      memWdata,
    output logic [6:0]       memProt,
    output logic             memNonsec,
    input  wire logic        memReady,
    input  wire logic [63:0] memRdata,
    input  wire logic        memErr
);

    // =====================================================
    // access state
    typedef enum logic {
        MAP_IDLE = 1'b0,
        MAP_WAIT = 1'b1
    } map_state_t;

    map_state_t  state;       // data access outstanding on apb

    // pin sampling
    logic [1:0]  syncA;       // first stage, read only by syncB
    logic [1:0]  syncB;       // {permit, enable} synchronised

    // stored control word fields
    logic        dbgSw;       // debug_software_permit
    logic        nonsec;      // AHB nonsecure request
    logic [3:0]  hprot;       // AHB protection bits
    logic [2:0]  pprot;       // APB4 protection bits
    logic [1:0]  step;        // address_step_mode
    logic [2:0]  size;        // AHB access size

    // address and upper data word
    logic [31:0] tar;         // transfer address
    logic [31:0] dataHi;      // upper half of doubleword

    // what the answer needs at the end
    logic        pendDw;      // outstanding access is data_window
    logic        pendDword;   // outstanding access is doubleword
    logic        pendHiLane;  // narrow read from upper lane

    // read image and its qualifiers
    logic [31:0] control_status_word;         // assembled read value
    logic        accessEnabled;
    logic        permit;
    logic        blocked;

    // apb decode
    logic        access;
    logic        selCsw;
    logic        selTar;
    logic        selDhi;
    logic        selData;
    logic        mapped;

    // engine handshake and attributes
    logic        start;
    logic        finish;
    logic [31:0] xAddr;
    logic [63:0] xWdata;
    logic [2:0]  xSize;
    logic [6:0]  xProt;

    // engine status
    logic        busy;
    logic        done;
    logic        doneErr;
    logic [63:0] rdata;

    // =====================================================
    // pin synchronisers
    // both pins share one two-stage chain
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            syncA <= 2'h0;
            syncB <= 2'h0;
        end else begin
            syncA <= {securePermitIn, accessEnableIn};
            syncB <= syncA;
        end
    end

    // both read live from the second stage
    // absent enable pin reads as one
    assign accessEnabled = HAS_ENABLE ? syncB[0] : 1'b1;
    // permit absent or APB2/3 reads zero
    assign permit = (HAS_SECURE && VARIANT != MAP_APB23) ? syncB[1] : 1'b0;

    // =====================================================
    // apb address decode
    // access phase of any transfer
    assign access  = psel && penable;
    assign selCsw  = paddr == MAP_OFS_CSW;
    assign selTar  = paddr == MAP_OFS_TAR;
    assign selDhi  = paddr == MAP_OFS_DHI;
    // banks: any word of the 0x10 page
    assign selData = (paddr == MAP_OFS_DW) || (paddr[7:4] == MAP_BD_PAGE && paddr[1:0] == 2'h0);
    assign mapped  = selCsw || selTar || selDhi || selData;

    // disabled port or unpermitted secure APB4 request never reaches memory
    assign blocked = !accessEnabled
        // a secure APB4 request needs the permit
        || (VARIANT == MAP_APB4 && !pprot[1] && !permit);

    // launch only when idle; a leftover aborted transfer stalls it
    assign start  = access && selData && state == MAP_IDLE && !blocked && !busy;
    // abort ends the apb wait, not the memory side
    assign finish = state == MAP_WAIT && (done || abortIn);

    // =====================================================
    // control word fields; reserved bits have no storage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            // reset image of the stored fields
            dbgSw  <= 1'b0;
            nonsec <= MAP_RST_NONSEC;
            hprot  <= MAP_RST_HPROT;
            pprot  <= MAP_RST_PPROT;
            step   <= MAP_STEP_OFF;
            size   <= MAP_SZ_WORD;
        end else if (access && pwrite && selCsw) begin
            // debug_software_permit is stored only
            dbgSw <= pwdata[MAP_BIT_DBGSW];
            if (VARIANT == MAP_AHB5) begin
                nonsec <= pwdata[MAP_BIT_NONSEC];
                hprot  <= pwdata[MAP_HP_HI:MAP_HP_LO];
                // packed step unsupported: only off or single kept
                if (pwdata[MAP_ST_HI:MAP_ST_LO] == MAP_STEP_ONE) begin
                    step <= MAP_STEP_ONE;
                end else begin
                    step <= MAP_STEP_OFF;
                end
                // byte..doubleword legal, other codes ignored
                if (pwdata[MAP_SZ_HI:MAP_SZ_LO] <= MAP_SZ_DWORD) begin
                    size <= pwdata[MAP_SZ_HI:MAP_SZ_LO];
                end
            end
            // APB4 keeps only protection besides debug_software_permit
            if (VARIANT == MAP_APB4) begin
                pprot <= pwdata[MAP_PP_HI:MAP_PP_LO];
            end
        end
    end

    // =====================================================
    // control word read image
    always_comb begin
        control_status_word = 32'h0;
        // bits common to every variant
        control_status_word[MAP_BIT_DBGSW]  = dbgSw;
        control_status_word[MAP_BIT_ACTIVE] = busy;
        control_status_word[MAP_BIT_ENAB]   = accessEnabled;
        control_status_word[MAP_BIT_PERMIT] = permit;
        unique case (VARIANT)
            MAP_AHB5: begin
                control_status_word[MAP_BIT_NONSEC]            = nonsec;
                control_status_word[MAP_HP_HI:MAP_HP_LO]       = hprot;
                control_status_word[MAP_ST_HI:MAP_ST_LO]       = step;
                control_status_word[MAP_SZ_HI:MAP_SZ_LO]       = size;
            end
            MAP_APB4: begin
                // bits 27..24 stay zero here
                control_status_word[MAP_PP_HI:MAP_PP_LO]       = pprot;
                control_status_word[MAP_SZ_HI:MAP_SZ_LO]       = MAP_SZ_WORD;
            end
            default: begin
                // no protection and no permit on APB2/3
                control_status_word[MAP_SZ_HI:MAP_SZ_LO]       = MAP_SZ_WORD;
            end
        endcase
    end

    // =====================================================
    // transfer attributes
    always_comb begin
        xSize  = (VARIANT == MAP_AHB5) ? size : MAP_SZ_WORD;
        // banked windows address within the 16-byte page
        xAddr  = tar; // data_window uses it as is
        if (paddr != MAP_OFS_DW) begin
            xAddr = {tar[31:4], paddr[3:2], 2'h0};
        end
        // narrow writes copy the word to both lanes
        if (xSize == MAP_SZ_DWORD) begin
            xWdata = {dataHi, pwdata};
        end else begin
            xWdata = {pwdata, pwdata};
        end
        if (VARIANT == MAP_AHB5) begin
            xProt = {hprot[3], 1'b0, hprot[3], hprot[3], hprot[2], hprot[1], hprot[0]};
        end else if (VARIANT == MAP_APB4) begin
            // secure only gets here with permit, so pprot passes as written
            xProt = {4'h0, pprot};
        end else begin
            // no protection driven on APB2/3
            xProt = 7'h0;
        end
    end

    // =====================================================
    // apb data access state
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state      <= MAP_IDLE;
            pendDw     <= 1'b0;
            pendDword  <= 1'b0;
            pendHiLane <= 1'b0;
        end else begin
            unique case (state)
                MAP_IDLE: begin
                    if (start) begin
                        // keep what the answer mux needs
                        state      <= MAP_WAIT;
                        pendDw     <= paddr == MAP_OFS_DW;
                        pendDword  <= xSize == MAP_SZ_DWORD;
                        pendHiLane <= xAddr[2];
                    end
                end
                MAP_WAIT: begin
                    // abort frees the bus; memory side runs on
                    if (finish) begin
                        state <= MAP_IDLE;
                    end
                end
            endcase
        end
    end

    // =====================================================
    // transfer address and upper data word
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tar    <= 32'h0;
            dataHi <= 32'h0;
        end else begin
            // a bus write wins over the step
            if (access && pwrite && selTar) begin
                tar <= pwdata;
            end else if (state == MAP_WAIT && done && !doneErr && pendDw
                         && step == MAP_STEP_ONE) begin
                // step by the access size; never in APB variants
                tar <= tar + (32'h1 << memSize);
            end
            if (access && pwrite && selDhi) begin
                dataHi <= pwdata;
            end else if (state == MAP_WAIT && done && !memWrite && pendDword) begin
                // doubleword read fills the upper word
                dataHi <= rdata[63:32];
            end
        end
    end

    // =====================================================
    // apb answer: register accesses finish at once
    always_comb begin
        pready  = 1'b1;
        pslverr = 1'b0;
        prdata  = 32'h0;
        if (access) begin
            // unmapped: error at once, nothing stored
            if (!mapped) begin
                pslverr = 1'b1;
            end else if (selData) begin
                // blocked access refuses at once
                if (state == MAP_IDLE) begin
                    pready  = blocked;
                    pslverr = blocked;
                end else begin
                    // wait for the engine or the abort pin
                    pready  = finish;
                    pslverr = abortIn || doneErr;
                    if (!pwrite && !abortIn) begin
                        // doubleword hands the low word first
                        prdata = (pendHiLane && !pendDword) ? rdata[63:32] : rdata[31:0];
                    end
                end
            end else if (!pwrite) begin
                // register reads need no wait state
                if (selCsw) begin
                    prdata = control_status_word;
                end else if (selTar) begin
                    prdata = tar;
                end else begin
                    prdata = dataHi;
                end
            end
        end
    end

    // =====================================================
    // memory-side engine
    map_xfer map_xfer_i (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .start     (start),
        .reqAddr   (xAddr),
        .reqWrite  (pwrite),
        .reqSize   (xSize),
        .reqWdata  (xWdata),
        .reqProt   (xProt),
        // nonsec exists only on the AHB side
        .reqNonsec (VARIANT == MAP_AHB5 ? nonsec : 1'b0),
        .memReq    (memReq),
        .memAddr   (memAddr),
        .memWrite  (memWrite),
        .memSize   (memSize),
        .memWdata  (memWdata),
        .memProt   (memProt),
        .memNonsec (memNonsec),
        .memReady  (memReady),
        .memRdata  (memRdata),
        .memErr    (memErr),
        .busy      (busy),
        .done      (done),
        .doneErr   (doneErr),
        .rdata     (rdata)
    );

endmodule

// ===== inc/map_pkg.sv
package map_pkg;

    // =====================================================
    // bus variant of the downstream port
    typedef enum logic [1:0] {
        MAP_AHB5  = 2'b00,
        MAP_APB23 = 2'b01,
        MAP_APB4  = 2'b10
    } map_variant_t;

    // =====================================================
    // register byte offsets
    localparam logic [7:0] MAP_OFS_CSW = 8'h00; // control_status_word
    localparam logic [7:0] MAP_OFS_TAR = 8'h04; // transfer address
    localparam logic [7:0] MAP_OFS_DHI = 8'h08; // upper data word
    localparam logic [7:0] MAP_OFS_DW  = 8'h0c; // data_window
    localparam logic [3:0] MAP_BD_PAGE = 4'h1;  // banked_data_windows 0x10..0x1c

    // =====================================================
    // control word field positions
    localparam int MAP_BIT_DBGSW  = 31; // debug_software_permit
    localparam int MAP_BIT_NONSEC = 30;
    localparam int MAP_PP_HI      = 30; // APB4 protection
    localparam int MAP_PP_LO      = 28;
    localparam int MAP_HP_HI      = 27; // AHB protection
    localparam int MAP_HP_LO      = 24;
    localparam int MAP_BIT_PERMIT = 23; // secure_debug_permit
    localparam int MAP_BIT_ACTIVE = 7;  // transfer_active
    localparam int MAP_BIT_ENAB   = 6;  // access_enabled
    localparam int MAP_ST_HI      = 5;  // address_step_mode
    localparam int MAP_ST_LO      = 4;
    localparam int MAP_SZ_HI      = 2;
    localparam int MAP_SZ_LO      = 0;

    // =====================================================
    // encodings and reset values
    localparam logic [2:0] MAP_SZ_BYTE    = 3'h0;
    localparam logic [2:0] MAP_SZ_HALF    = 3'h1;
    localparam logic [2:0] MAP_SZ_WORD    = 3'h2;
    localparam logic [2:0] MAP_SZ_DWORD   = 3'h3;
    localparam logic [1:0] MAP_STEP_OFF   = 2'h0;
    localparam logic [1:0] MAP_STEP_ONE   = 2'h1;
    localparam logic [3:0] MAP_RST_HPROT  = 4'h3;
    localparam logic [2:0] MAP_RST_PPROT  = 3'h2;
    localparam logic       MAP_RST_NONSEC = 1'b1;

endpackage

// ===== rtl/map_xfer.sv
`timescale 1ns/1ps
// =========================================================
// downstream transfer engine: one request held until ready
module map_xfer
    import map_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        start,     // one-cycle launch
    input  wire logic [31:0] reqAddr,
    input  wire logic        reqWrite,
    input  wire logic [2:0]  reqSize,
    input  wire logic [63:0] reqWdata,
    input  wire logic [6:0]  reqProt,
    input  wire logic        reqNonsec,
    output logic             memReq,
    output logic [31:0]      memAddr,
    output logic             memWrite,
    output logic [2:0]       memSize,
    output logic [63:0]      memWdata,
    output logic [6:0]       memProt,
    output logic             memNonsec,
    input  wire logic        memReady,
    input  wire logic [63:0] memRdata,
    input  wire logic        memErr,
    output logic             busy,      // transfer on the memory side
    output logic             done,      // one-cycle completion
    output logic             doneErr,
    output logic [63:0]      rdata
);

    // =====================================================
    // request hold: attributes frozen for the whole transfer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            memReq    <= 1'b0;
            memAddr   <= 32'h0;
            memWrite  <= 1'b0;
            memSize   <= MAP_SZ_WORD;
            memWdata  <= 64'h0;
            memProt   <= 7'h0;
            memNonsec <= 1'b0;
        end else if (start && !memReq) begin
            memReq    <= 1'b1;
            memAddr   <= reqAddr;
            memWrite  <= reqWrite;
            memSize   <= reqSize;
            memWdata  <= reqWdata;
            memProt   <= reqProt;
            memNonsec <= reqNonsec;
        end else if (memReq && memReady) begin
            memReq <= 1'b0;
        end
    end

    // busy equals a pending request; an abort never drops it
    assign busy = memReq;

    // =====================================================
    // completion capture
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            done    <= 1'b0;
            doneErr <= 1'b0;
            rdata   <= 64'h0;
        end else begin
            done <= memReq && memReady;
            if (memReq && memReady) begin
                doneErr <= memErr;
                rdata   <= memRdata;
            end
        end
    end

endmodule

// ===== sim/map_mem_model.sv
`timescale 1ns/1ps
// =====================================
// memory side stand-in, adjustable wait
module map_mem_model
    import map_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    input  wire logic        memWrite,
    input  wire logic [2:0]  memSize,
    input  wire logic [63:0] memWdata,
    input  wire logic [6:0]  memProt,
    input  wire logic [3:0]  waitN,
    output logic             memReady,
    output logic [63:0]      memRdata,
    output logic             memErr,
    output logic [15:0]      xferCount,
    output logic [6:0]       lastProt
);
    logic [63:0] mem [0:15];        // small backing store
    logic [3:0]  cnt;               // wait cycles spent
    wire  [3:0]  idx = memAddr[6:3];
    // answer once waitN cycles passed
    assign memReady = memReq && cnt >= waitN;
    // outside the answer show inverse, so stale data never passes
    assign memRdata = memReady ? mem[idx] : ~mem[idx];
    assign memErr   = memReady ? memAddr[31] : cnt[0];
    // =====================================
    // byte-masked store and bookkeeping
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            xferCount <= 16'h0;
            lastProt <= 7'h0;
        end else if (memReady) begin
            cnt <= 4'h0;
            xferCount <= xferCount + 16'h1;
            lastProt <= memProt;
            for (int b = 0; b < 8; b++)
                if (memWrite && b >= memAddr[2:0] && b < memAddr[2:0] + (1 << memSize))
                    mem[idx][8*b +: 8] <= memWdata[8*b +: 8];
        end else if (memReq) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ===== sim/map_ctrl_word_chk.sv
`timescale 1ns/1ps
// =====================================
// pin-level checker of the control word
module map_ctrl_word_chk
    import map_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        accessEnableIn,
    input wire logic        securePermitIn,
    input wire logic        memReq,
    input wire logic [31:0] memAddr,
    input wire logic [2:0]  memSize,
    input wire logic [6:0]  memProt,
    input wire logic        memReady
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [1:0] up;     // edges since reset, sync lag guard
    wire  cswRd = psel & penable & !pwrite & (paddr == MAP_OFS_CSW);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    // =====================================
    // properties
    property p_prot5; memReq |-> !memProt[5]; endproperty
    a_prot5: assert property (p_prot5) else $error("prot bit 5 high");
    property p_fan; memReq |-> memProt[6] == memProt[3] && memProt[4] == memProt[3]; endproperty
    a_fan: assert property (p_fan) else $error("prot fan-out split");
    property p_busy; cswRd |-> prdata[7] == memReq; endproperty
    a_busy: assert property (p_busy) else $error("active bit wrong");
    property p_resv; cswRd |-> prdata[22:8] == 15'h0 && !prdata[3]; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_enab; $stable(accessEnableIn)[*3] ##0 (cswRd && up == 2'h3) |-> prdata[6] == accessEnableIn;
    endproperty
    a_enab: assert property (p_enab) else $error("enable bit wrong");
    property p_perm; $stable(securePermitIn)[*3] ##0 (cswRd && up == 2'h3) |-> prdata[23] == securePermitIn;
    endproperty
    a_perm: assert property (p_perm) else $error("permit bit wrong");
    property p_size; cswRd |-> prdata[2:0] <= MAP_SZ_DWORD && !prdata[5]; endproperty
    a_size: assert property (p_size) else $error("size or step illegal");
    property p_issue; (!accessEnableIn)[*4] |-> !$rose(memReq); endproperty
    a_issue: assert property (p_issue) else $error("transfer while disabled");
    property p_unmap; psel && penable && paddr >= 8'h20 |-> pready && pslverr && prdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
    property p_hold; memReq && !memReady |=> memReq && $stable(memAddr) && $stable(memProt); endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
    c_abort: cover property (psel && penable && pready && pslverr && memReq);
    c_wide: cover property (memReq && memReady && memSize == MAP_SZ_DWORD);
    c_slow: cover property (memReq && !memReady ##1 memReq && memReady);
endmodule
bind map_ctrl_word map_ctrl_word_chk map_ctrl_word_chk_i (.*);

// ===== sim/tb_map_ctrl_word.sv
`timescale 1ns/1ps
// =====================================
// bench: register access and memory side
module tb_map_ctrl_word import map_pkg::*; ();
    logic        sys_clk = 1'b0, nrst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic        accessEnableIn = 1'b1, securePermitIn = 1'b1;
    logic        abortIn = 1'b0, abortArm = 1'b0;
    logic [3:0]  waitN = 4'h0;
    logic [15:0] seed = 16'h1bed;   // fixed start, 7149
    wire         pready, pslverr, memReq, memWrite, memNonsec, memReady, memErr;
    wire  [31:0] prdata, memAddr;
    wire  [2:0]  memSize;
    wire  [63:0] memWdata, memRdata;
    wire  [6:0]  memProt, lastProt;
    wire  [15:0] xferCount;
    int          errors = 0, checks = 0, cyc = 0;
    map_ctrl_word map_ctrl_word_i (.*);
    map_mem_model map_mem_model_i (.*);
    always #2 sys_clk = ~sys_clk;
    // abort pin follows the arm flag while a transfer hangs
    always @(posedge sys_clk) abortIn <= abortArm & memReq;
    // hang guard, several times a clean run's length
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end
    // =====================================
    // expectation helpers
    function automatic logic [31:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return {seed, ~seed[7:0], seed[15:8]};
    endfunction
    // stored csw after a write: step 01 kept, oversize ignored
    function automatic logic [31:0] cswWr(logic [31:0] o, logic [31:0] w);
        return {w[31:30], 2'b00, w[27:24], 18'h0, (w[5:4] == MAP_STEP_ONE) ? 2'b01 : 2'b00,
                1'b0, (w[2:0] <= MAP_SZ_DWORD) ? w[2:0] : o[2:0]};
    endfunction
    function automatic logic [31:0] laneMask(logic [31:0] a, int s);
        logic [63:0] m;
        m = (64'h1 << (8 << s)) - 64'h1;
        return m[31:0] << (8 * a[1:0]);
    endfunction
    // =====================================
    // apb master: pready sampled at the rising edge that takes it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic results();
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // =====================================
    // main sequence
    initial begin
        logic [31:0] r, control_status_word, w, a, d, hi;
        logic [15:0] n;
        logic        e;
        int          s;
        control_status_word = 32'h43000002;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, MAP_OFS_CSW, 32'h0, r, e);
        cmp(r, control_status_word | 32'h00800040, "csw reset");
        wr(MAP_OFS_CSW, 32'hffffffff);
        control_status_word = cswWr(control_status_word, 32'hffffffff);
        apb(1'b0, MAP_OFS_CSW, 32'h0, r, e);
        cmp(r, control_status_word | 32'h00800040, "csw all ones");
        apb(1'b0, 8'h40, 32'h0, r, e);
        cmp({r[31:1], e}, 32'h1, "unmapped");
        // every size, random prot, data, address and wait
        for (int i = 0; i < 16; i++) begin
            s = i % 4;
            a = rnd() & 32'h7f & ~((32'h1 << s) - 32'h1);
            w = (rnd() & 32'h4f000000) | s;
            d = rnd();
            hi = rnd();
            waitN <= 4'(rnd() & 32'h3);
            wr(MAP_OFS_CSW, w);
            wr(MAP_OFS_TAR, a);
            wr(MAP_OFS_DHI, hi);
            wr(MAP_OFS_DW, d);
            cmp({24'h0, memNonsec, lastProt}, {24'h0, w[30], w[27], 1'b0, w[27], w[27], w[26:24]}, "prot");
            wr(MAP_OFS_CSW, w | 32'h10);
            apb(1'b0, MAP_OFS_DW, 32'h0, r, e);
            cmp(r & laneMask(a, s), d & laneMask(a, s), "read data");
            apb(1'b0, MAP_OFS_TAR, 32'h0, r, e);
            cmp(r, a + (32'h1 << s), "address step");
            if (s == 3) begin
                apb(1'b0, MAP_OFS_DHI, 32'h0, r, e);
                cmp(r, hi, "upper word");
            end
        end
        // disabled port refuses without a transfer
        accessEnableIn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, MAP_OFS_CSW, 32'h0, r, e);
        cmp(r & 32'h40, 32'h0, "enable bit");
        n = xferCount;
        apb(1'b0, MAP_OFS_DW, 32'h0, r, e);
        cmp({e, 15'h0, xferCount}, {1'b1, 15'h0, n}, "blocked");
        accessEnableIn <= 1'b1;
        // permit bit ignores writes
        securePermitIn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(MAP_OFS_CSW, 32'h00800002);
        apb(1'b0, MAP_OFS_CSW, 32'h0, r, e);
        cmp(r & 32'h00800000, 32'h0, "permit read only");
        securePermitIn <= 1'b1;
        // abort a slow access, transfer keeps running
        waitN <= 4'hf;
        abortArm <= 1'b1;
        apb(1'b0, MAP_OFS_DW, 32'h0, r, e);
        abortArm <= 1'b0;
        cmp({31'h0, e}, 32'h1, "abort error");
        apb(1'b0, MAP_OFS_CSW, 32'h0, r, e);
        cmp(r & 32'h80, 32'h80, "still active");
        repeat (20) @(posedge sys_clk);
        apb(1'b0, MAP_OFS_CSW, 32'h0, r, e);
        cmp(r & 32'h80, 32'h0, "idle again");
        results();
    end
endmodule
